// ---- eeprom_pkg.sv ----
package eeprom_pkg;
   // ==========================================
   // geometry
   localparam int ADDR_BITS_DEF   = 11;
   localparam int PAGE_BYTES      = 32;
   localparam int PAGE_BITS       = 5;
   // ==========================================
   // command codes
   localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
   localparam logic [7:0] CMD_ARRAY_WRITE   = 8'h02;
   localparam logic [7:0] CMD_ARRAY_READ    = 8'h03;
   localparam logic [7:0] CMD_DISABLE_WRITE = 8'h04;
   localparam logic [7:0] CMD_STATUS_READ   = 8'h05;
   localparam logic [7:0] CMD_ENABLE_WRITE  = 8'h06;
   // ==========================================
   // status byte layout
   localparam int ST_LOCK_POS     = 7;
   localparam int ST_PROT_HI_POS  = 3;
   localparam int ST_PROT_LO_POS  = 2;
   localparam int ST_LATCH_POS    = 1;
   localparam int ST_BUSY_POS     = 0;
   localparam logic       LOCK_RESET  = 1'b0;
   localparam logic [1:0] PROT_RESET  = 2'b00;
   localparam logic       LATCH_RESET = 1'b0;
   // idle levels of {wp_n, mosi, sck, cs_n} held in the synchroniser at reset
   localparam logic [3:0] PIN_IDLE    = 4'h9;
   // ==========================================
   // protect field codes
   localparam logic [1:0] PROT_NONE    = 2'b00;
   localparam logic [1:0] PROT_QUARTER = 2'b01;
   localparam logic [1:0] PROT_HALF    = 2'b10;
   localparam logic [1:0] PROT_ALL     = 2'b11;
   // ==========================================
   // self-timed cycle lengths
   localparam int CLK_PERIOD_NS        = 10;
   localparam int STATUS_CYCLE_TIME_US = 5;
   localparam int ARRAY_CYCLE_TIME_US  = 5;
   localparam int STATUS_CYCLES =
      (STATUS_CYCLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ARRAY_CYCLES =
      (ARRAY_CYCLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_BITS = 24;
   // ==========================================
   // states
   typedef enum logic [5:0] {
      PH_CMD     = 6'b000001,
      PH_ADDR_HI = 6'b000010,
      PH_ADDR_LO = 6'b000100,
      PH_DATA    = 6'b001000,
      PH_HOLD    = 6'b010000,
      PH_DROP    = 6'b100000
   } phase_type;
   typedef enum logic [2:0] {
      ENG_IDLE   = 3'b001,
      ENG_STATUS = 3'b010,
      ENG_ARRAY  = 3'b100
   } engine_type;
endpackage : eeprom_pkg

// ---- bit_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int               WIDTH = 4,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   input  wire logic             clk_sys_in,
   input  wire logic             arst_n_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // ==========================================
   // two-stage synchroniser
   always_comb
   begin
      meta_d = d_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         meta_q <= INIT;
         sync_q <= INIT;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign q_out = sync_q;
endmodule : bit_sync
`default_nettype wire

// ---- cycle_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
   parameter int WIDTH = 24
) (
   input  wire logic             clk_sys_in,
   input  wire logic             arst_n_in,
   input  wire logic             start_in,
   input  wire logic [WIDTH-1:0] load_in,
   output logic                  done_out
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;

   // ==========================================
   // countdown, done pulses on the last cycle
   always_comb
   begin
      cnt_d = cnt_q;
      if (start_in)
         cnt_d = load_in;
      else if (cnt_q != '0)
         cnt_d = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   assign done_out = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1}) && !start_in;
endmodule : cycle_timer
`default_nettype wire

// ---- spi_eeprom_status_rw.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_status_rw #(
   parameter int ADDR_BITS     = eeprom_pkg::ADDR_BITS_DEF,
   parameter int STATUS_CYCLES = eeprom_pkg::STATUS_CYCLES,
   parameter int ARRAY_CYCLES  = eeprom_pkg::ARRAY_CYCLES
) (
   input  wire logic       clk_sys_in,
   input  wire logic       arst_n_in,
   input  wire logic       cs_n_in,
   input  wire logic       sck_in,
   input  wire logic       mosi_in,
   input  wire logic       wp_n_in,
   output logic            miso_out,
   output logic            miso_oe_out,
   output logic [7:0]      status_out,
   output logic            hw_lock_out
);
   localparam int PB = eeprom_pkg::PAGE_BITS;
   localparam int TB = eeprom_pkg::TIMER_BITS;

   // ==========================================
   // pin synchronisation and edges
   logic [3:0] pins_s;
   logic       cs_n_s;
   logic       sck_s;
   logic       mosi_s;
   logic       wp_n_s;
   logic       sck_prev_q;
   logic       cs_prev_q;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_rise;
   logic       active;

   // reset to the idle pin levels so no false chip select edge follows reset
   bit_sync #(.WIDTH(4), .INIT(eeprom_pkg::PIN_IDLE)) u_sync (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .d_in       ({wp_n_in, mosi_in, sck_in, cs_n_in}),
      .q_out      (pins_s)
   );

   assign cs_n_s   = pins_s[0];
   assign sck_s    = pins_s[1];
   assign mosi_s   = pins_s[2];
   assign wp_n_s   = pins_s[3];
   assign active   = !cs_n_s;
   assign sck_rise = sck_s && !sck_prev_q && active;
   assign sck_fall = !sck_s && sck_prev_q && active;
   assign cs_rise  = cs_n_s && !cs_prev_q;

   // ==========================================
   // state
   eeprom_pkg::phase_type  phase_q, phase_d;
   eeprom_pkg::engine_type eng_q, eng_d;
   logic [2:0]             bit_cnt_q, bit_cnt_d;
   logic [7:0]             shift_q, shift_d;
   logic [7:0]             cmd_q, cmd_d;
   logic [7:0]             addr_hi_q, addr_hi_d;
   logic [ADDR_BITS-1:0]   addr_q, addr_d;
   logic [ADDR_BITS-PB-1:0] page_q, page_d;
   logic [1:0]             data_cnt_q, data_cnt_d;
   logic [7:0]             sr_data_q, sr_data_d;
   logic                   latch_q, latch_d;
   logic                   lock_q, lock_d;
   logic [1:0]             prot_q, prot_d;
   logic [7:0]             out_sh_q, out_sh_d;
   logic                   miso_q, miso_d;
   logic [eeprom_pkg::PAGE_BYTES-1:0] mask_q, mask_d;

   logic [7:0]             mem [2**ADDR_BITS];
   logic [7:0]             pbuf [eeprom_pkg::PAGE_BYTES];

   logic [7:0]             rx_byte;
   logic                   byte_done;
   logic [15:0]            full_addr;
   logic [ADDR_BITS-1:0]   load_addr;
   logic [ADDR_BITS-1:0]   addr_inc;
   logic                   busy;
   logic                   hw_lock;
   logic                   frame_ok;
   logic                   sr_go;
   logic                   arr_go;
   logic                   arr_prot;
   logic                   pbuf_we;
   logic                   commit;
   logic                   tmr_done;
   logic [7:0]             status_byte;

   function automatic logic page_protected(input logic [1:0] prot, input logic [1:0] top);
      logic hit;
      hit = 1'b0;
      unique case (prot)
         eeprom_pkg::PROT_NONE:    hit = 1'b0;
         eeprom_pkg::PROT_QUARTER: hit = (top == 2'b11);
         eeprom_pkg::PROT_HALF:    hit = top[1];
         eeprom_pkg::PROT_ALL:     hit = 1'b1;
      endcase
      return hit;
   endfunction : page_protected

   // ==========================================
   // decode
   assign rx_byte   = {shift_q[6:0], mosi_s};
   assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
   assign full_addr = {addr_hi_q, rx_byte};
   assign load_addr = full_addr[ADDR_BITS-1:0];
   assign addr_inc  = addr_q + {{(ADDR_BITS-1){1'b0}}, 1'b1};
   assign busy      = (eng_q != eeprom_pkg::ENG_IDLE);
   assign hw_lock   = lock_q && !wp_n_s;
   assign frame_ok  = (phase_q == eeprom_pkg::PH_DATA) && (bit_cnt_q == 3'h0);
   assign arr_prot  = page_protected(prot_q, addr_q[ADDR_BITS-1 -: 2]);
   assign sr_go     = cs_rise && frame_ok && (cmd_q == eeprom_pkg::CMD_STATUS_WRITE)
                      && (data_cnt_q == 2'h1) && latch_q && !busy && !hw_lock;
   assign arr_go    = cs_rise && frame_ok && (cmd_q == eeprom_pkg::CMD_ARRAY_WRITE)
                      && (data_cnt_q != 2'h0) && latch_q && !busy && !arr_prot;
   assign pbuf_we   = byte_done && (phase_q == eeprom_pkg::PH_DATA)
                      && (cmd_q == eeprom_pkg::CMD_ARRAY_WRITE) && !busy;
   assign commit    = tmr_done && (eng_q == eeprom_pkg::ENG_ARRAY);

   always_comb
   begin
      status_byte = 8'h00;
      status_byte[eeprom_pkg::ST_LOCK_POS]    = lock_q;
      status_byte[eeprom_pkg::ST_PROT_HI_POS] = prot_q[1];
      status_byte[eeprom_pkg::ST_PROT_LO_POS] = prot_q[0];
      status_byte[eeprom_pkg::ST_LATCH_POS]   = latch_q;
      status_byte[eeprom_pkg::ST_BUSY_POS]    = busy;
   end

   cycle_timer #(.WIDTH(TB)) u_timer (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .start_in   (sr_go || arr_go),
      .load_in    (sr_go ? TB'(STATUS_CYCLES) : TB'(ARRAY_CYCLES)),
      .done_out   (tmr_done)
   );

   // ==========================================
   // next state
   always_comb
   begin
      phase_d    = phase_q;
      eng_d      = eng_q;
      bit_cnt_d  = bit_cnt_q;
      shift_d    = shift_q;
      cmd_d      = cmd_q;
      addr_hi_d  = addr_hi_q;
      addr_d     = addr_q;
      page_d     = page_q;
      data_cnt_d = data_cnt_q;
      sr_data_d  = sr_data_q;
      latch_d    = latch_q;
      lock_d     = lock_q;
      prot_d     = prot_q;
      out_sh_d   = out_sh_q;
      miso_d     = miso_q;
      mask_d     = mask_q;
      if (!active)
      begin
         phase_d    = eeprom_pkg::PH_CMD;
         bit_cnt_d  = 3'h0;
         data_cnt_d = 2'h0;
      end
      else if (sck_rise)
      begin
         shift_d   = rx_byte;
         bit_cnt_d = bit_cnt_q + 3'h1;
         unique case (phase_q)
            eeprom_pkg::PH_CMD:
               if (bit_cnt_q == 3'h7)
               begin
                  cmd_d = rx_byte;
                  unique case (rx_byte)
                     eeprom_pkg::CMD_ARRAY_READ:
                        phase_d = busy ? eeprom_pkg::PH_DROP : eeprom_pkg::PH_ADDR_HI;
                     eeprom_pkg::CMD_ARRAY_WRITE:
                        phase_d = eeprom_pkg::PH_ADDR_HI;
                     eeprom_pkg::CMD_STATUS_WRITE:
                        phase_d = eeprom_pkg::PH_DATA;
                     eeprom_pkg::CMD_STATUS_READ:
                     begin
                        phase_d  = eeprom_pkg::PH_DATA;
                        out_sh_d = status_byte;
                     end
                     eeprom_pkg::CMD_ENABLE_WRITE,
                     eeprom_pkg::CMD_DISABLE_WRITE:
                        phase_d = eeprom_pkg::PH_HOLD;
                     default:
                        phase_d = eeprom_pkg::PH_DROP;
                  endcase
               end
            eeprom_pkg::PH_ADDR_HI:
               if (bit_cnt_q == 3'h7)
               begin
                  addr_hi_d = rx_byte;
                  phase_d   = eeprom_pkg::PH_ADDR_LO;
               end
            eeprom_pkg::PH_ADDR_LO:
               if (bit_cnt_q == 3'h7)
               begin
                  addr_d  = load_addr;
                  phase_d = eeprom_pkg::PH_DATA;
                  if (cmd_q == eeprom_pkg::CMD_ARRAY_READ)
                     out_sh_d = mem[load_addr];
                  else if (!busy)
                     mask_d = '0;
               end
            eeprom_pkg::PH_DATA:
               if (bit_cnt_q == 3'h7)
               begin
                  if (data_cnt_q != 2'h3)
                     data_cnt_d = data_cnt_q + 2'h1;
                  if (cmd_q == eeprom_pkg::CMD_ARRAY_READ)
                  begin
                     addr_d   = addr_inc;
                     out_sh_d = mem[addr_inc];
                  end
                  else if (cmd_q == eeprom_pkg::CMD_STATUS_READ)
                     out_sh_d = status_byte;
                  else if (cmd_q == eeprom_pkg::CMD_STATUS_WRITE)
                     sr_data_d = rx_byte;
                  else if (pbuf_we)
                  begin
                     mask_d[addr_q[PB-1:0]] = 1'b1;
                     addr_d = {addr_q[ADDR_BITS-1:PB], addr_q[PB-1:0] + {{(PB-1){1'b0}}, 1'b1}};
                  end
               end
            eeprom_pkg::PH_HOLD:
               phase_d = eeprom_pkg::PH_DROP;
            eeprom_pkg::PH_DROP:
               phase_d = eeprom_pkg::PH_DROP;
         endcase
      end
      else if (sck_fall && (phase_q == eeprom_pkg::PH_DATA))
      begin
         miso_d   = out_sh_q[7];
         out_sh_d = {out_sh_q[6:0], 1'b0};
      end
      if (cs_rise && (phase_q == eeprom_pkg::PH_HOLD) && !busy)
      begin
         if (cmd_q == eeprom_pkg::CMD_ENABLE_WRITE)
            latch_d = 1'b1;
         else if (cmd_q == eeprom_pkg::CMD_DISABLE_WRITE)
            latch_d = 1'b0;
      end
      if (sr_go)
         eng_d = eeprom_pkg::ENG_STATUS;
      if (arr_go)
      begin
         eng_d  = eeprom_pkg::ENG_ARRAY;
         page_d = addr_q[ADDR_BITS-1:PB];
      end
      if (tmr_done && busy)
      begin
         eng_d   = eeprom_pkg::ENG_IDLE;
         latch_d = 1'b0;
         if (eng_q == eeprom_pkg::ENG_STATUS)
         begin
            lock_d = sr_data_q[eeprom_pkg::ST_LOCK_POS];
            prot_d = {sr_data_q[eeprom_pkg::ST_PROT_HI_POS], sr_data_q[eeprom_pkg::ST_PROT_LO_POS]};
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
         phase_q    <= eeprom_pkg::PH_CMD;
         eng_q      <= eeprom_pkg::ENG_IDLE;
         bit_cnt_q  <= 3'h0;
         shift_q    <= 8'h00;
         cmd_q      <= 8'h00;
         addr_hi_q  <= 8'h00;
         addr_q     <= '0;
         page_q     <= '0;
         data_cnt_q <= 2'h0;
         sr_data_q  <= 8'h00;
         latch_q    <= eeprom_pkg::LATCH_RESET;
         lock_q     <= eeprom_pkg::LOCK_RESET;
         prot_q     <= eeprom_pkg::PROT_RESET;
         out_sh_q   <= 8'h00;
         miso_q     <= 1'b0;
         mask_q     <= '0;
      end
      else
      begin
         sck_prev_q <= sck_s;
         cs_prev_q  <= cs_n_s;
         phase_q    <= phase_d;
         eng_q      <= eng_d;
         bit_cnt_q  <= bit_cnt_d;
         shift_q    <= shift_d;
         cmd_q      <= cmd_d;
         addr_hi_q  <= addr_hi_d;
         addr_q     <= addr_d;
         page_q     <= page_d;
         data_cnt_q <= data_cnt_d;
         sr_data_q  <= sr_data_d;
         latch_q    <= latch_d;
         lock_q     <= lock_d;
         prot_q     <= prot_d;
         out_sh_q   <= out_sh_d;
         miso_q     <= miso_d;
         mask_q     <= mask_d;
      end
   end

   // ==========================================
   // page buffer and array storage
   always_ff @(posedge clk_sys_in)
   begin
      if (pbuf_we)
         pbuf[addr_q[PB-1:0]] <= rx_byte;
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++)
         if (commit && mask_q[i])
            mem[{page_q, PB'(i)}] <= pbuf[i];
   end

   assign miso_out    = miso_q;
   assign miso_oe_out = active && (phase_q == eeprom_pkg::PH_DATA)
                        && ((cmd_q == eeprom_pkg::CMD_ARRAY_READ)
                        || (cmd_q == eeprom_pkg::CMD_STATUS_READ));
   assign status_out  = status_byte;
   assign hw_lock_out = hw_lock;

   // ==========================================
   // assertions
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   property p_latch_needed;
      (sr_go || arr_go) |-> latch_q;
   endproperty
   a_latch_needed: assert property (p_latch_needed) else $error("write started without latch");
   property p_status_busy;
      sr_go |=> busy ##1 busy;
   endproperty
   a_status_busy: assert property (p_status_busy) else $error("status cycle not busy");
   property p_latch_clear;
      (tmr_done && busy) |=> !latch_q && !busy;
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch kept after cycle");
   property p_zero_bits;
      status_out[6:4] == 3'h0 && status_out[0] == busy;
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("status fixed bits wrong");
   property p_frozen;
      (busy && !tmr_done) |=> $stable(lock_q) && $stable(prot_q);
   endproperty
   a_frozen: assert property (p_frozen) else $error("lock or protect changed early");
   property p_hw_reject;
      (lock_q && !wp_n_s) |-> !sr_go;
   endproperty
   a_hw_reject: assert property (p_hw_reject) else $error("status write under hardware lock");
   property p_read_busy;
      (byte_done && phase_q == eeprom_pkg::PH_CMD && rx_byte == eeprom_pkg::CMD_ARRAY_READ && busy)
         |=> phase_q == eeprom_pkg::PH_DROP;
   endproperty
   a_read_busy: assert property (p_read_busy) else $error("read accepted while busy");
   property p_read_inc;
      (byte_done && phase_q == eeprom_pkg::PH_DATA && cmd_q == eeprom_pkg::CMD_ARRAY_READ)
         |=> addr_q == ADDR_BITS'($past(addr_q) + 1);
   endproperty
   a_read_inc: assert property (p_read_inc) else $error("read address not advanced");
   property p_page_wrap;
      pbuf_we |=> addr_q[ADDR_BITS-1:PB] == $past(addr_q[ADDR_BITS-1:PB]);
   endproperty
   a_page_wrap: assert property (p_page_wrap) else $error("write left its page");
   property p_arr_reject;
      arr_go |-> !arr_prot && !busy && bit_cnt_q == 3'h0;
   endproperty
   a_arr_reject: assert property (p_arr_reject) else $error("bad array write started");
   property p_cs_end;
      cs_rise |=> phase_q == eeprom_pkg::PH_CMD && bit_cnt_q == 3'h0 && !miso_oe_out;
   endproperty
   a_cs_end: assert property (p_cs_end) else $error("frame not ended");

   c_status_write: cover property (sr_go);
   c_array_write: cover property (arr_go);
   c_read_wrap: cover property (byte_done && cmd_q == eeprom_pkg::CMD_ARRAY_READ
                                && phase_q == eeprom_pkg::PH_DATA && addr_inc == '0);
   c_hw_locked: cover property (cs_rise && frame_ok && hw_lock && latch_q
                                && cmd_q == eeprom_pkg::CMD_STATUS_WRITE);
endmodule : spi_eeprom_status_rw
`default_nettype wire

// ---- spi_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====
// host controller model
module spi_host (
   input  wire logic clk_sys_in,
   input  wire logic miso_in,
   output logic      cs_n_out,
   output logic      sck_out,
   output logic      mosi_out
);
   logic [7:0] rx;
   initial
   begin
      cs_n_out = 1'b1;
      sck_out  = 1'b0;
      mosi_out = 1'b0;
   end
   // top n bits of b, msb first, sck idles low between frames
   task automatic send(input logic [7:0] b, input int n = 8);
      for (int i = 7; i > 7 - n; i--)
      begin
         if (cs_n_out)
         begin
            cs_n_out <= 1'b0;
            repeat (4) @(posedge clk_sys_in);
         end
         mosi_out <= b[i];
         repeat (4) @(posedge clk_sys_in);
         sck_out <= 1'b1;
         rx[i] = miso_in;
         repeat (4) @(posedge clk_sys_in);
         sck_out <= 1'b0;
      end
   endtask : send
   // released data line shows the inverse of its last bit
   task automatic stop();
      repeat (4) @(posedge clk_sys_in);
      cs_n_out <= 1'b1;
      mosi_out <= ~mosi_out;
      repeat (6) @(posedge clk_sys_in);
   endtask : stop
endmodule : spi_host
`default_nettype wire

// ---- spi_eeprom_status_rw_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_status_rw_test;
   logic       clk_sys_in;
   logic       arst_n_in;
   logic       wp_n_in;
   logic       cs_n;
   logic       sck;
   logic       mosi;
   logic       miso_out;
   logic       miso_oe_out;
   logic       hw_lock_out;
   logic [7:0] status_out;
   int         err_total = 0;
   int         n_compared = 0;
   // =====
   // status write rows: pin, data, status mid-cycle, status after
   logic [7:0] rows [6][4] = '{'{8'h01, 8'hFF, 8'h03, 8'h8C}, '{8'h00, 8'h00, 8'h8E, 8'h8E},
      '{8'h01, 8'h04, 8'h8F, 8'h04}, '{8'h00, 8'h08, 8'h07, 8'h08},
      '{8'h00, 8'h0C, 8'h0B, 8'h0C}, '{8'h01, 8'h00, 8'h0F, 8'h00}};
   spi_eeprom_status_rw #(.STATUS_CYCLES(20), .ARRAY_CYCLES(400)) spi_eeprom_status_rw_inst (
      .clk_sys_in  (clk_sys_in),
      .arst_n_in   (arst_n_in),
      .cs_n_in     (cs_n),
      .sck_in      (sck),
      .mosi_in     (mosi),
      .wp_n_in     (wp_n_in),
      .miso_out    (miso_out),
      .miso_oe_out (miso_oe_out),
      .status_out  (status_out),
      .hw_lock_out (hw_lock_out)
   );
   spi_host spi_host_inst (
      .clk_sys_in (clk_sys_in),
      .miso_in    (miso_out),
      .cs_n_out   (cs_n),
      .sck_out    (sck),
      .mosi_out   (mosi)
   );
   // =====
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      if (err_total == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic cmd(input logic [7:0] c);
      spi_host_inst.send(c);
      spi_host_inst.stop();
   endtask : cmd
   task automatic head(input logic [7:0] c, input logic [15:0] a);
      spi_host_inst.send(c);
      spi_host_inst.send(a[15:8]);
      spi_host_inst.send(a[7:0]);
   endtask : head
   task automatic rd(input logic [7:0] exp);
      spi_host_inst.send(8'h00);
      check(spi_host_inst.rx, exp);
   endtask : rd
   // =====
   // clock and watchdog
   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   initial
   begin
      #300000;
      err_total++;
      finish_test();
   end
   // =====
   // main sequence
   initial
   begin
      arst_n_in = 1'b0;
      wp_n_in = 1'b1;
      repeat (2) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      check(status_out, 8'h00);
      foreach (rows[i])
      begin
         wp_n_in <= rows[i][0][0];
         cmd(eeprom_pkg::CMD_ENABLE_WRITE);
         spi_host_inst.send(eeprom_pkg::CMD_STATUS_WRITE);
         spi_host_inst.send(rows[i][1]);
         spi_host_inst.stop();
         #1 check(status_out, rows[i][2]);
         repeat (30) @(posedge clk_sys_in);
         #1 check(status_out, rows[i][3]);
         check({7'h00, hw_lock_out}, {7'h00, rows[i][3][7] & ~rows[i][0][0]});
      end
      spi_host_inst.send(eeprom_pkg::CMD_STATUS_WRITE);
      spi_host_inst.send(8'h0C);
      spi_host_inst.stop();
      #1 check(status_out, 8'h00);
      cmd(eeprom_pkg::CMD_ENABLE_WRITE);
      spi_host_inst.send(eeprom_pkg::CMD_STATUS_WRITE);
      spi_host_inst.send(8'h0C, 7);
      spi_host_inst.stop();
      #1 check(status_out, 8'h02);
      head(eeprom_pkg::CMD_ARRAY_WRITE, 16'h0000);
      spi_host_inst.send(8'h11);
      spi_host_inst.stop();
      #1 check(status_out, 8'h03);
      spi_host_inst.send(eeprom_pkg::CMD_STATUS_READ);
      rd(8'h03);
      spi_host_inst.stop();
      repeat (410) @(posedge clk_sys_in);
      #1 check(status_out, 8'h00);
      cmd(eeprom_pkg::CMD_ENABLE_WRITE);
      head(eeprom_pkg::CMD_ARRAY_WRITE, 16'h07FE);
      spi_host_inst.send(8'hA5);
      spi_host_inst.send(8'h5A);
      spi_host_inst.send(8'hC3);
      spi_host_inst.stop();
      head(eeprom_pkg::CMD_ARRAY_READ, 16'h07FE);
      spi_host_inst.send(8'h00, 4);
      #1 check({7'h00, miso_oe_out}, 8'h00);
      spi_host_inst.stop();
      repeat (410) @(posedge clk_sys_in);
      head(eeprom_pkg::CMD_ARRAY_READ, 16'hF7FF);
      rd(8'h5A);
      #1 check({7'h00, miso_oe_out}, 8'h01);
      rd(8'h11);
      spi_host_inst.stop();
      head(eeprom_pkg::CMD_ARRAY_READ, 16'h07E0);
      rd(8'hC3);
      spi_host_inst.send(8'h00, 3);
      spi_host_inst.stop();
      #1 check({7'h00, miso_oe_out}, 8'h00);
      head(eeprom_pkg::CMD_ARRAY_READ, 16'h07FE);
      rd(8'hA5);
      spi_host_inst.stop();
      cmd(eeprom_pkg::CMD_ENABLE_WRITE);
      spi_host_inst.send(eeprom_pkg::CMD_STATUS_WRITE);
      spi_host_inst.send(8'h04);
      spi_host_inst.stop();
      repeat (30) @(posedge clk_sys_in);
      cmd(eeprom_pkg::CMD_ENABLE_WRITE);
      head(eeprom_pkg::CMD_ARRAY_WRITE, 16'h07E0);
      spi_host_inst.send(8'h00);
      spi_host_inst.stop();
      #1 check(status_out, 8'h06);
      cmd(eeprom_pkg::CMD_DISABLE_WRITE);
      #1 check(status_out, 8'h04);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      #1 check(status_out, 8'h00);
      check({7'h00, hw_lock_out}, 8'h00);
      finish_test();
   end
endmodule : spi_eeprom_status_rw_test
`default_nettype wire
